// File: cpuam_decoder.sv
// operand addressing decoder: fetches operand bytes and forms addresses
`timescale 1ns/1ps
`include "cpuam_defines.svh"
module cpuam_decoder
   import cpuam_pkg::*;
#(
   parameter logic [15:0] RESET_PC = `CPUAM_PC_RESET
)
(
   input wire logic clk_sys,
   input wire logic rst_n,
   input wire logic [7:0] mem_rdata,
   input wire logic [7:0] idx_x,
   input wire logic [7:0] idx_y,
   input wire logic irq_wake,
   output logic [15:0] mem_addr,
   output logic mem_rd,
   output logic [15:0] pc,
   output logic [7:0] opcode,
   output logic instr_done,
   output logic [15:0] ea,
   output logic ea_valid,
   output logic [7:0] operand,
   output logic imm_valid,
   output logic [15:0] rel_target,
   output logic rel_valid,
   output logic use_y,
   output logic rmw_op,
   output logic [1:0] irq_level,
   output logic osc_stop,
   output logic low_power
);

   // ----------------------------------------
   // state and adders
   // ----------------------------------------
   cpuam_regs_type q;
   cpuam_regs_type n;
   cpuam_info_type dec;
   logic [15:0] sum_ea;
   logic [15:0] sum_tgt;
   logic is_pfx;

   cpuam_ea_add u_add
   (
      .base(q.base),
      .index(q.use_y ? idx_y : idx_x),
      .use_index(q.info.idx),
      .pc(q.pc),
      .offset(q.off),
      .ea(sum_ea),
      .target(sum_tgt)
   );

   // ----------------------------------------
   // opcode classification
   // ----------------------------------------
   // the high nibble picks the addressing group; a pointer prebyte turns
   // the direct groups and the indexed groups other than 7 and F into their indirect forms
   function automatic cpuam_info_type am_decode(input logic [7:0] op, input logic [7:0] pfx);
      cpuam_info_type i;
      logic ind;
      i = '0;
      ind = (pfx == `CPUAM_PFX_IND) || (pfx == `CPUAM_PFX_IY);
      case (op[7:4])
         4'h0:
         begin
            // bit test and branch: address, optional pointer, then offset
            i.nargs = 2'd1;
            i.ptrw = {1'b0, ind};
            i.rel_pc = 1'b1;
            i.rmw = 1'b1;
            i.zp = 1'b1;
            i.mem = 1'b1;
         end
         4'h1, 4'h3:
         begin
            i.nargs = 2'd1;
            i.ptrw = {1'b0, ind};
            i.rmw = 1'b1;
            i.zp = 1'b1;
            i.mem = 1'b1;
         end
         4'h2:
         begin
            // relative jump; indirect takes the offset from page zero
            i.nargs = {1'b0, ind};
            i.rel_pc = !ind;
            i.rel_ptr = ind;
         end
         4'h6:
         begin
            i.nargs = 2'd1;
            i.ptrw = {1'b0, ind};
            i.idx = 1'b1;
            i.rmw = 1'b1;
            i.mem = 1'b1;
         end
         4'h7, 4'hF:
         begin
            i.idx = 1'b1;
            i.rmw = (op[7:4] == 4'h7);
            i.zp = 1'b1;
            i.mem = 1'b1;
         end
         4'hA:
         begin
            i.nargs = 2'd1;
            i.imm = 1'b1;
         end
         4'hB:
         begin
            i.nargs = 2'd1;
            i.ptrw = {1'b0, ind};
            i.zp = 1'b1;
            i.mem = 1'b1;
         end
         4'hC, 4'hD:
         begin
            // long forms; indirect keeps one pointer byte, reads a word
            i.nargs = ind ? 2'd1 : 2'd2;
            i.ptrw = ind ? 2'd2 : 2'd0;
            i.idx = (op[7:4] == 4'hD);
            i.mem = 1'b1;
         end
         4'hE:
         begin
            i.nargs = 2'd1;
            i.ptrw = {1'b0, ind};
            i.idx = 1'b1;
            i.mem = 1'b1;
         end
         default:
         begin
            // inherent groups: nothing follows the opcode
            i = '0;
         end
      endcase
      return i;
   endfunction

   assign dec = am_decode(mem_rdata, q.pfx);
   assign is_pfx = (mem_rdata == `CPUAM_PFX_Y) || (mem_rdata == `CPUAM_PFX_IY)
                 || (mem_rdata == `CPUAM_PFX_IND);

   // ----------------------------------------
   // next state
   // ----------------------------------------
   // each byte is a two-cycle step: issue the read, then take the data,
   // which memory presents while mem_rd is high
   always_comb
   begin
      n = q;
      n.rd = 1'b0;
      n.ea_v = 1'b0;
      n.imm_v = 1'b0;
      n.rel_v = 1'b0;
      n.done = 1'b0;
      n.sync1 = irq_wake;
      n.sync2 = q.sync1;
      case (q.st)
         ST_OPC:
         begin
            if (!q.pend)
            begin
               n.rd = 1'b1;
               n.addr = q.pc;
               n.pend = 1'b1;
            end
            else
            begin
               n.pend = 1'b0;
               n.pc = q.pc + 16'h0001;
               if (is_pfx)
               begin
                  n.pfx = mem_rdata;
               end
               else
               begin
                  n.opc = mem_rdata;
                  n.ins_pc = q.pc;
                  n.info = dec;
                  n.cnt = dec.nargs;
                  n.base = 16'h0000;
                  // both 90 and 91 move the indexing onto the second register
                  n.use_y = (q.pfx == `CPUAM_PFX_Y) || (q.pfx == `CPUAM_PFX_IY);
                  if (dec.nargs != 2'd0)
                     n.st = ST_ARG;
                  else if (dec.rel_pc)
                     n.st = ST_REL;
                  else
                     n.st = ST_DONE;
               end
            end
         end
         ST_ARG:
         begin
            if (!q.pend)
            begin
               n.rd = 1'b1;
               n.addr = q.pc;
               n.pend = 1'b1;
            end
            else
            begin
               n.pend = 1'b0;
               n.pc = q.pc + 16'h0001;
               // high byte comes first, so shifting builds the word
               n.base = {q.base[7:0], mem_rdata};
               n.ptr = mem_rdata;
               n.cnt = q.cnt - 2'd1;
               if (q.cnt == 2'd1)
               begin
                  if (q.info.ptrw != 2'd0)
                  begin
                     n.st = ST_PTR;
                     n.cnt = q.info.ptrw;
                     n.base = 16'h0000;
                  end
                  else if (q.info.rel_pc || q.info.rel_ptr)
                     n.st = ST_REL;
                  else
                     n.st = ST_DONE;
               end
            end
         end
         ST_PTR:
         begin
            if (!q.pend)
            begin
               n.rd = 1'b1;
               n.addr = {`CPUAM_ZP_HI, q.ptr};
               n.pend = 1'b1;
            end
            else
            begin
               n.pend = 1'b0;
               // a word pointer's second byte stays inside page zero
               n.ptr = q.ptr + 8'h01;
               n.base = {q.base[7:0], mem_rdata};
               n.cnt = q.cnt - 2'd1;
               if (q.cnt == 2'd1)
                  n.st = q.info.rel_pc ? ST_REL : ST_DONE;
            end
         end
         ST_REL:
         begin
            if (!q.pend)
            begin
               n.rd = 1'b1;
               n.addr = q.info.rel_ptr ? {`CPUAM_ZP_HI, q.base[7:0]} : q.pc;
               n.pend = 1'b1;
            end
            else
            begin
               n.pend = 1'b0;
               n.off = mem_rdata;
               if (!q.info.rel_ptr)
                  n.pc = q.pc + 16'h0001;
               n.st = ST_DONE;
            end
         end
         ST_DONE:
         begin
            n.done = 1'b1;
            n.ea = sum_ea;
            n.ea_v = q.info.mem;
            n.operand = q.base[7:0];
            n.imm_v = q.info.imm;
            n.rel_tgt = sum_tgt;
            n.rel_v = q.info.rel_pc || q.info.rel_ptr;
            n.pfx = `CPUAM_PFX_NONE;
            n.st = ST_OPC;
            if (q.opc == `CPUAM_OP_MASK)
               n.lvl = `CPUAM_LVL_MASKED;
            if (q.opc == `CPUAM_OP_UNMASK)
               n.lvl = `CPUAM_LVL_OPEN;
            if (q.opc == `CPUAM_OP_HALT)
            begin
               n.osc_stop = 1'b1;
               n.low_pwr = 1'b1;
               n.st = ST_HALT;
            end
            if (q.opc == `CPUAM_OP_SLEEP)
            begin
               n.low_pwr = 1'b1;
               n.st = ST_SLEEP;
            end
         end
         ST_HALT, ST_SLEEP:
         begin
            // only an interrupt ends either low power state
            if (q.sync2)
            begin
               n.osc_stop = 1'b0;
               n.low_pwr = 1'b0;
               n.st = ST_OPC;
            end
         end
         default:
         begin
            n.st = ST_OPC;
            n.pend = 1'b0;
         end
      endcase
   end

   // ----------------------------------------
   // state register
   // ----------------------------------------
   // interrupts start masked, as software must open them explicitly
   always_ff @(posedge clk_sys or negedge rst_n)
   begin
      if (!rst_n)
      begin
         q <= '0;
         q.st <= ST_OPC;
         q.pc <= RESET_PC;
         q.lvl <= `CPUAM_LVL_MASKED;
      end
      else
      begin
         q <= n;
      end
   end

   // ----------------------------------------
   // outputs
   // ----------------------------------------
   assign mem_addr = q.addr;
   assign mem_rd = q.rd;
   assign pc = q.pc;
   assign opcode = q.opc;
   assign instr_done = q.done;
   assign ea = q.ea;
   assign ea_valid = q.ea_v;
   assign operand = q.operand;
   assign imm_valid = q.imm_v;
   assign rel_target = q.rel_tgt;
   assign rel_valid = q.rel_v;
   assign use_y = q.use_y;
   assign rmw_op = q.info.rmw;
   assign irq_level = q.lvl;
   assign osc_stop = q.osc_stop;
   assign low_power = q.low_pwr;

   // ----------------------------------------
   // checks
   // ----------------------------------------
   default clocking cb @(posedge clk_sys);
   endclocking
   default disable iff (!rst_n);

   sequence s_halt_taken;
      instr_done && (opcode == `CPUAM_OP_HALT);
   endsequence

   sequence s_stopped_wait;
      osc_stop && low_power && (q.st == ST_HALT);
   endsequence

   chk_zero_page: assert property (ea_valid && q.info.zp |-> ea[15:8] == 8'h00)
      else $error("short form left page zero");
   chk_short_index: assert property (ea_valid && q.info.idx && q.info.nargs != 2'd2
      && q.info.ptrw != 2'd2 |-> ea <= `CPUAM_SHORT_IDX_MAX)
      else $error("short indexed address above 1FE");
   chk_rmw_short: assert property (ea_valid && q.info.rmw |-> ea <= `CPUAM_SHORT_IDX_MAX)
      else $error("rmw operand beyond short reach");
   chk_inherent_len: assert property (instr_done && q.info.nargs == 2'd0 && q.info.ptrw == 2'd0
      && !q.info.rel_pc |-> pc == q.ins_pc + 16'h0001)
      else $error("inherent instruction not one byte");
   chk_imm_len: assert property (imm_valid |-> pc == q.ins_pc + 16'h0002)
      else $error("immediate instruction not two bytes");
   chk_long_len: assert property (instr_done && q.info.nargs == 2'd2
      |-> pc == q.ins_pc + 16'h0003)
      else $error("long form not three bytes");
   chk_index_sum: assert property (ea_valid && q.info.idx
      |-> ea == q.base + {8'h00, (use_y ? $past(idx_y) : $past(idx_x))})
      else $error("indexed address is not base plus index");
   chk_ptr_page: assert property (mem_rd && q.st == ST_PTR |-> mem_addr[15:8] == 8'h00)
      else $error("pointer read outside page zero");
   chk_mask_level: assert property (instr_done && opcode == `CPUAM_OP_MASK
      |-> irq_level == 2'h3)
      else $error("mask instruction did not raise level");
   chk_halt_stop: assert property (s_halt_taken |-> s_stopped_wait ##1 (osc_stop || q.sync2 == 1'b0
      || q.st == ST_OPC))
      else $error("halt did not stop the oscillator");
   chk_rel_target: assert property (rel_valid |-> rel_target == $past(q.pc)
      + {{8{q.off[7]}}, q.off})
      else $error("relative target wrong");
   chk_read_pulse: assert property (mem_rd |=> !mem_rd)
      else $error("memory read longer than one cycle");

endmodule // cpuam_decoder

// File: cpuam_defines.svh
// constants of the cpu operand addressing decoder
`ifndef CPUAM_DEFINES_SVH
`define CPUAM_DEFINES_SVH

// ----------------------------------------
// prebytes and special opcodes
// ----------------------------------------
`define CPUAM_PFX_NONE 8'h00
`define CPUAM_PFX_Y 8'h90
`define CPUAM_PFX_IY 8'h91
`define CPUAM_PFX_IND 8'h92
`define CPUAM_OP_MASK 8'h9B
`define CPUAM_OP_UNMASK 8'h9A
`define CPUAM_OP_HALT 8'h8E
`define CPUAM_OP_SLEEP 8'h8F

// ----------------------------------------
// reset values and address limits
// ----------------------------------------
`define CPUAM_PC_RESET 16'h0000
`define CPUAM_LVL_MASKED 2'h3
`define CPUAM_LVL_OPEN 2'h0
`define CPUAM_ZP_HI 8'h00
`define CPUAM_SHORT_IDX_MAX 16'h01FE

`endif

// File: cpuam_pkg.sv
// types of the cpu operand addressing decoder
package cpuam_pkg;

   // ----------------------------------------
   // sequencer states, one-hot
   // ----------------------------------------
   typedef enum logic [6:0] {
      ST_OPC = 7'h01,
      ST_ARG = 7'h02,
      ST_PTR = 7'h04,
      ST_REL = 7'h08,
      ST_DONE = 7'h10,
      ST_HALT = 7'h20,
      ST_SLEEP = 7'h40
   } cpuam_state_type;

   // ----------------------------------------
   // addressing mode summary of one opcode
   // ----------------------------------------
   typedef struct packed {
      logic [1:0] nargs;
      logic [1:0] ptrw;
      logic idx;
      logic rel_pc;
      logic rel_ptr;
      logic rmw;
      logic zp;
      logic mem;
      logic imm;
   } cpuam_info_type;

   // ----------------------------------------
   // whole state of the decoder
   // ----------------------------------------
   typedef struct packed {
      cpuam_state_type st;
      logic pend;
      logic rd;
      logic [15:0] addr;
      logic [15:0] pc;
      logic [15:0] ins_pc;
      logic [7:0] opc;
      logic [7:0] pfx;
      cpuam_info_type info;
      logic [1:0] cnt;
      logic [7:0] ptr;
      logic [15:0] base;
      logic [7:0] off;
      logic [15:0] ea;
      logic ea_v;
      logic imm_v;
      logic [7:0] operand;
      logic [15:0] rel_tgt;
      logic rel_v;
      logic done;
      logic use_y;
      logic [1:0] lvl;
      logic osc_stop;
      logic low_pwr;
      logic sync1;
      logic sync2;
   } cpuam_regs_type;

endpackage

// File: cpuam_ea_add.sv
// effective address and branch target adders
`timescale 1ns/1ps
module cpuam_ea_add
(
   input wire logic [15:0] base,
   input wire logic [7:0] index,
   input wire logic use_index,
   input wire logic [15:0] pc,
   input wire logic [7:0] offset,
   output logic [15:0] ea,
   output logic [15:0] target
);

   // ----------------------------------------
   // adders
   // ----------------------------------------
   // full 16-bit sum so a short offset plus index lands above page zero
   assign ea = base + {8'h00, (use_index ? index : 8'h00)};
   // offset is sign extended, giving a reach of -128..+127
   assign target = pc + {{8{offset[7]}}, offset};

endmodule // cpuam_ea_add

// File: cpuam_mem_model.sv
// behavioural program and data memory seen by the operand addressing decoder
`timescale 1ns/1ps
module cpuam_mem_model
(
   input wire logic clk_sys,
   input wire logic mem_rd,
   input wire logic [15:0] mem_addr,
   output logic [7:0] mem_rdata
);
   // ----------------------------------------
   // storage and read port
   // ----------------------------------------
   logic [7:0] mem [0:65535];
   logic [7:0] last_q = 8'hA5;

   // same-cycle answer; between reads the bus shows the inverse of the last
   // byte, so a sample taken outside the strobe cannot match by luck
   always_comb mem_rdata = mem_rd ? mem[mem_addr] : ~last_q;

   // remember the byte last handed out
   always @(posedge clk_sys)
      if (mem_rd)
         last_q <= mem[mem_addr];
endmodule // cpuam_mem_model

// File: tb.sv
// self-checking bench of the operand addressing decoder
`timescale 1ns/1ps
module tb;
   import cpuam_pkg::*;
   // ----------------------------------------
   // clock, stimulus and design
   // ----------------------------------------
   localparam logic [15:0] START = 16'h0400;
   localparam int NR = 20;
   typedef struct packed {
      logic [7:0] pfx;
      logic [7:0] opc;
      logic [1:0] nb;
      logic [7:0] a0;
      logic [7:0] a1;
      logic [15:0] ea;
      logic [4:0] fl;
      logic [7:0] roff;
   } cpuam_row_type;
   logic clk_sys = 1'b0;
   logic rst_n = 1'b0;
   logic irq_wake = 1'b0;
   logic [7:0] idx_x = 8'hFF;
   logic [7:0] idx_y = 8'h81;
   logic [7:0] mem_rdata, opcode, operand;
   logic [15:0] mem_addr, pc, ea, rel_target, wa;
   logic mem_rd, instr_done, ea_valid, imm_valid, rel_valid, use_y, rmw_op, osc_stop, low_power;
   logic [1:0] irq_level;
   logic [15:0] exp_pc [NR];
   int n_fail = 0;
   int samples_checked = 0;
   // flags: ea_valid, imm_valid, rel_valid, rmw_op, use_y; index x = FF, y = 81
   cpuam_row_type rows [NR] = '{
      '{8'h00, 8'h9D, 2'h0, 8'h00, 8'h00, 16'h0000, 5'h00, 8'h00},
      '{8'h00, 8'hA6, 2'h1, 8'h55, 8'h00, 16'h0000, 5'h08, 8'h00},
      '{8'h00, 8'hB6, 2'h1, 8'h10, 8'h00, 16'h0010, 5'h10, 8'h00},
      '{8'h00, 8'hC6, 2'h2, 8'h12, 8'h34, 16'h1234, 5'h10, 8'h00},
      '{8'h00, 8'hF6, 2'h0, 8'h00, 8'h00, 16'h00FF, 5'h10, 8'h00},
      '{8'h00, 8'hE6, 2'h1, 8'hFF, 8'h00, 16'h01FE, 5'h10, 8'h00},
      '{8'h00, 8'hD6, 2'h2, 8'h12, 8'h34, 16'h1333, 5'h10, 8'h00},
      '{8'h90, 8'hF6, 2'h0, 8'h00, 8'h00, 16'h0081, 5'h11, 8'h00},
      '{8'h92, 8'hB6, 2'h1, 8'h10, 8'h00, 16'h00F0, 5'h10, 8'h00},
      '{8'h92, 8'hC6, 2'h1, 8'h10, 8'h00, 16'hF02A, 5'h10, 8'h00},
      '{8'h92, 8'hE6, 2'h1, 8'h10, 8'h00, 16'h01EF, 5'h10, 8'h00},
      '{8'h91, 8'hE6, 2'h1, 8'h10, 8'h00, 16'h0171, 5'h11, 8'h00},
      '{8'h92, 8'hD6, 2'h1, 8'hFF, 8'h00, 16'h5777, 5'h10, 8'h00},
      '{8'h00, 8'h20, 2'h1, 8'hFE, 8'h00, 16'h0000, 5'h04, 8'hFE},
      '{8'h92, 8'h20, 2'h1, 8'h10, 8'h00, 16'h0000, 5'h04, 8'hF0},
      '{8'h00, 8'h3A, 2'h1, 8'h10, 8'h00, 16'h0010, 5'h12, 8'h00},
      '{8'h00, 8'h7C, 2'h0, 8'h00, 8'h00, 16'h00FF, 5'h12, 8'h00},
      '{8'h00, 8'h6C, 2'h1, 8'h80, 8'h00, 16'h017F, 5'h12, 8'h00},
      '{8'h00, 8'h10, 2'h1, 8'h10, 8'h00, 16'h0010, 5'h12, 8'h00},
      '{8'h00, 8'h00, 2'h2, 8'h10, 8'h05, 16'h0010, 5'h16, 8'h05}
   };

   // free-running core clock, 5 ns period
   always #2.5 clk_sys = ~clk_sys;

   cpuam_decoder #(.RESET_PC(START)) u_dut
   (
      .clk_sys, .rst_n, .mem_rdata, .idx_x, .idx_y, .irq_wake, .mem_addr, .mem_rd, .pc,
      .opcode, .instr_done, .ea, .ea_valid, .operand, .imm_valid, .rel_target, .rel_valid,
      .use_y, .rmw_op, .irq_level, .osc_stop, .low_power
   );
   cpuam_mem_model u_mem (.clk_sys, .mem_rd, .mem_addr, .mem_rdata);

   // ----------------------------------------
   // shared tasks
   // ----------------------------------------
   task automatic close_out();
      $display("comparisons %0d, mismatches %0d", samples_checked, n_fail);
      if (n_fail == 0 && samples_checked > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask

   task automatic cmp_w(input logic [15:0] got, input logic [15:0] exp);
      samples_checked++;
      if (got !== exp)
      begin
         n_fail++;
         $display("Error at %0t: got 0x%0h expected 0x%0h", $time, got, exp);
      end
   endtask

   task automatic cmp_f(input logic got, input logic exp);
      samples_checked++;
      if (got !== exp)
      begin
         n_fail++;
         $display("Error at %0t: flag got 0x%0h expected 0x%0h", $time, got, exp);
      end
   endtask

   // bounded wait on a flag; running out counts a mismatch and ends the run
   task automatic wait_for(ref logic sig, input logic val);
      int k;
      k = 0;
      @(negedge clk_sys);
      while (sig !== val && k < 60)
      begin
         @(negedge clk_sys);
         k++;
      end
      if (k >= 60)
      begin
         cmp_f(sig, val);
         close_out();
      end
   endtask

   task automatic put(input logic [7:0] b);
      u_mem.mem[wa] = b;
      wa = wa + 16'h0001;
   endtask

   // ----------------------------------------
   // main sequence
   // ----------------------------------------
   initial
   begin
      for (int a = 0; a < 65536; a++)
         u_mem.mem[a] = 8'h9D;
      // page-zero pointers; the word at FF wraps to 00 for its low byte
      u_mem.mem[16'h0010] = 8'hF0;
      u_mem.mem[16'h0011] = 8'h2A;
      u_mem.mem[16'h00FF] = 8'h56;
      u_mem.mem[16'h0000] = 8'h78;
      wa = START;
      for (int i = 0; i < NR; i++)
      begin
         if (rows[i].pfx !== 8'h00)
            put(rows[i].pfx);
         put(rows[i].opc);
         if (rows[i].nb > 2'h0)
            put(rows[i].a0);
         if (rows[i].nb > 2'h1)
            put(rows[i].a1);
         exp_pc[i] = wa;
      end
      // unmask, mask, halt, two spacers, wait
      put(8'h9A);
      put(8'h9B);
      put(8'h8E);
      wa = wa + 16'h0002;
      put(8'h8F);
      repeat (16) @(negedge clk_sys);
      cmp_w(pc, START);
      cmp_w({14'h0000, irq_level}, 16'h0003);
      cmp_f(mem_rd, 1'b0);
      rst_n = 1'b1;
      // table rows run back to back from the start address
      for (int i = 0; i < NR; i++)
      begin
         wait_for(instr_done, 1'b1);
         cmp_w(pc, exp_pc[i]);
         cmp_w({8'h00, opcode}, {8'h00, rows[i].opc});
         cmp_f(ea_valid, rows[i].fl[4]);
         if (rows[i].fl[4])
            cmp_w(ea, rows[i].ea);
         cmp_f(imm_valid, rows[i].fl[3]);
         if (rows[i].fl[3])
            cmp_w({8'h00, operand}, {8'h00, rows[i].a0});
         cmp_f(rel_valid, rows[i].fl[2]);
         if (rows[i].fl[2])
            cmp_w(rel_target, exp_pc[i] + {{8{rows[i].roff[7]}}, rows[i].roff});
         cmp_f(rmw_op, rows[i].fl[1]);
         cmp_f(use_y, rows[i].fl[0]);
      end
      wait_for(instr_done, 1'b1);
      cmp_w({14'h0000, irq_level}, 16'h0000);
      wait_for(instr_done, 1'b1);
      cmp_w({14'h0000, irq_level}, 16'h0003);
      // halt holds until the wake request crosses its synchroniser
      wait_for(instr_done, 1'b1);
      cmp_f(osc_stop, 1'b1);
      repeat (8) @(negedge clk_sys);
      cmp_f(low_power, 1'b1);
      irq_wake = 1'b1;
      wait_for(low_power, 1'b0);
      irq_wake = 1'b0;
      cmp_f(osc_stop, 1'b0);
      wait_for(instr_done, 1'b1);
      wait_for(instr_done, 1'b1);
      wait_for(instr_done, 1'b1);
      cmp_f(low_power, 1'b1);
      cmp_f(osc_stop, 1'b0);
      irq_wake = 1'b1;
      wait_for(low_power, 1'b0);
      irq_wake = 1'b0;
      // second reset in mid-run restarts from the start address
      rst_n = 1'b0;
      @(negedge clk_sys);
      cmp_w(pc, START);
      cmp_w({14'h0000, irq_level}, 16'h0003);
      rst_n = 1'b1;
      wait_for(instr_done, 1'b1);
      cmp_w(pc, START + 16'h0001);
      close_out();
   end
endmodule // tb
